// >>> dv/ddr_dram_bus_read_and_data_order_bench.sv
// Purpose: Self-checking bench for the DDR bus DRAM slave
// Assumes: Array model answers each fetch within one clk
// Notes: Expected words come from a fixed address pattern
`default_nettype none

module ddr_dram_bus_read_and_data_order_bench;
  import ddr_bus_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic ck, cs_b, smi, smo, dqoe_b, smoe_b;
  logic [7:0] dqi, dqo;
  logic [3:0] latency_count = 4'h2;
  logic refresh_pending = 1'h0;
  logic [1:0] wrap_len_sel = 2'h0;
  logic [15:0] mem_rdata = 16'h0000;
  mem_req_t mem_req;
  mem_req_t wr_q[$];
  int fails = 0;
  int n_tests = 0;
  int n_open = 0;
  logic [31:0] open_addr = 32'h0;

  always #5 clk = ~clk;

  dram_bus_slave dut_u
  (
    .clk(clk),
    .rst_b(rst_b),
    .bus_clock_line(ck),
    .chip_select_b(cs_b),
    .dq_in(dqi),
    .dq_out(dqo),
    .dq_oe_b(dqoe_b),
    .strobe_mask_line_in(smi),
    .strobe_mask_line_out(smo),
    .strobe_mask_line_oe_b(smoe_b),
    .latency_count(latency_count),
    .refresh_pending(refresh_pending),
    .wrap_len_sel(wrap_len_sel),
    .mem_rdata(mem_rdata),
    .mem_req(mem_req)
  );

  host_model host_u
  (
    .clk(clk),
    .bus_clock_line(ck),
    .chip_select_b(cs_b),
    .dq_in(dqi),
    .strobe_mask_line_in(smi),
    .dq_out(dqo),
    .dq_oe_b(dqoe_b),
    .strobe_mask_line_out(smo),
    .strobe_mask_line_oe_b(smoe_b)
  );

  // ==========================================================
  // Array model
  function automatic logic [15:0] pat(input logic [31:0] a);
    return {a[7:0] ^ 8'h3c, a[7:0] + 8'h51};
  endfunction

  function automatic logic [22:0] nxt(input logic [22:0] a, input int i, input int len);
    return len == 0 ? a + 23'(i) : (a & ~23'(len - 1)) | ((a + 23'(i)) & 23'(len - 1));
  endfunction

  always @(posedge clk)
  begin
    if (mem_req.rd)
      mem_rdata <= pat(mem_req.addr);
    if (mem_req.wr)
      wr_q.push_back(mem_req);
    if (mem_req.open)
    begin
      n_open++;
      open_addr <= mem_req.addr;
    end
  end

  // ==========================================================
  // Checks and transfers
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    begin
      n_tests++;
      if (got !== exp)
      begin
        fails++;
        $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
    end
  endtask

  task automatic rd(input logic rg, input logic [22:0] a, input int w, input int lat,
    input int len);
    int d;
    begin
      n_open = 0;
      host_u.xfer({1'h1, rg, len == 0, 9'h000, a[22:3], 13'h0000, a[2:0]}, 2 * lat, 2 * w,
        1'h0);
      d = host_u.first - 7 - 2 * lat;
      chk(64'(d == 0 || d == 1), 64'h1, "first data edge");
      chk(host_u.rq.size(), 2 * w, "byte count");
      for (int i = 0; i < w; i++)
        chk({host_u.rq[2 * i], host_u.rq[2 * i + 1]}, pat(nxt(a, i, len)), "word");
      chk({dqoe_b, smoe_b}, 2'h3, "release");
      chk({n_open, open_addr}, {32'h1, 9'h000, a[22:3], 3'h0}, "row open");
    end
  endtask

  task automatic wr(input logic rg, input logic [22:0] a, input logic [31:0] d,
    input logic [3:0] m, input int lat);
    begin
      wr_q.delete();
      for (int i = 0; i < 4; i++)
        host_u.wq.push_back({m[3 - i], d[31 - 8 * i -: 8]});
      host_u.xfer({1'h0, rg, 1'h1, 9'h000, a[22:3], 13'h0000, a[2:0]}, 2 * lat, 4, !rg);
      chk(wr_q.size(), 2, "write count");
      for (int k = 0; k < 2; k++)
        chk({wr_q[k].reg_space, wr_q[k].addr, wr_q[k].wdata, wr_q[k].be},
          {rg, 32'(a + 23'(k)), d[31 - 16 * k -: 16],
          rg ? 2'h3 : ~{m[3 - 2 * k], m[2 - 2 * k]}}, "write");
    end
  endtask

  task automatic conclude();
    begin
      $display("Comparisons %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask

  // ==========================================================
  // Sequence
  initial
  begin
    repeat (6) @(posedge clk);
    rst_b <= 1'h1;
    repeat (8) @(posedge clk);
    for (int s = 0; s < 4; s++)
    begin
      @(posedge clk);
      latency_count <= 4'(s);
      wrap_len_sel <= 2'(s);
      rd(1'h0, 23'h001200 + 23'((8 << s) - 2), 3, s, 8 << s);
    end
    @(posedge clk);
    latency_count <= 4'h2;
    refresh_pending <= 1'h1;
    rd(1'h0, 23'h7ffffe, 3, 4, 0);
    @(posedge clk);
    refresh_pending <= 1'h0;
    rd(1'h1, 23'h000001, 2, 2, 0);
    wr(1'h0, 23'h000105, 32'ha1b2c3d4, 4'h9, 2);
    wr(1'h1, 23'h000000, 32'h5e6f7081, 4'h6, 0);
    conclude();
  end

  // Whole sequence needs about 9 us; over ten times that means a hang
  initial
  begin
    #100us;
    fails++;
    conclude();
  end
endmodule // ddr_dram_bus_read_and_data_order_bench

`default_nettype wire

// >>> dv/host_model.sv
// Purpose: Host master model for the DDR bus DRAM slave
// Assumes: Bus clock halves of 6 or 7 clk, 125 ns a period on average
// Notes: Read bytes are taken on each strobe transition of the device
`default_nettype none

module host_model
(
  input wire logic clk,
  output logic bus_clock_line,
  output logic chip_select_b,
  output logic [7:0] dq_in,
  output logic strobe_mask_line_in,
  input wire logic [7:0] dq_out,
  input wire logic dq_oe_b,
  input wire logic strobe_mask_line_out,
  input wire logic strobe_mask_line_oe_b
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] dq_h = 8'h00;
  logic mask_h = 1'h0;
  logic mask_en = 1'h0;
  logic last_s = 1'h0;
  logic prev_s = 1'h0;
  int n = 0;
  int first = 0;
  logic [7:0] rq[$];
  logic [8:0] wq[$];

  initial
  begin
    bus_clock_line = 1'h0;
    chip_select_b = 1'h1;
  end

  // ==========================================================
  // Pins and read capture
  // Released strobe shows the host mask while mask_en is set, else the inverse of its last level
  assign strobe_mask_line_in = !strobe_mask_line_oe_b ? strobe_mask_line_out :
    mask_en ? mask_h : ~last_s;
  assign dq_in = dq_oe_b ? dq_h : dq_out;

  always @(posedge clk)
  begin
    if (!strobe_mask_line_oe_b)
      last_s <= strobe_mask_line_out;
    else if (mask_en)
      last_s <= mask_h;
    prev_s <= strobe_mask_line_oe_b ? 1'h0 : strobe_mask_line_out;
    if (!strobe_mask_line_oe_b && !dq_oe_b && strobe_mask_line_out != prev_s)
    begin
      rq.push_back(dq_out);
      if (first == 0)
        first = n;
    end
  end

  // ==========================================================
  // Bus clock edges
  task automatic tick(input logic [7:0] d, input logic m);
    int h;
    begin
      h = (n % 4 == 3) ? 7 : 6;
      repeat (3) @(posedge clk);
      dq_h <= d;
      mask_h <= m;
      repeat (h - 3) @(posedge clk);
      bus_clock_line <= ~bus_clock_line;
      n <= n + 1;
    end
  endtask

  // Even edge counts only, so select always rises with the clock low
  task automatic xfer(input logic [47:0] ca, input int pre, input int edges, input logic men);
    logic [8:0] v;
    begin
      n <= 0;
      first = 0;
      rq.delete();
      @(posedge clk);
      chip_select_b <= 1'h0;
      for (int i = 5; i >= 0; i--)
        tick(ca[i * 8 +: 8], 1'h0);
      mask_en <= men;
      for (int i = 0; i < pre + edges; i++)
      begin
        v = (i >= pre && i - pre < wq.size()) ? wq[i - pre] : 9'h000;
        tick(v[7:0], v[8]);
      end
      repeat (8) @(posedge clk);
      chip_select_b <= 1'h1;
      mask_en <= 1'h0;
      wq.delete();
      repeat (8) @(posedge clk);
    end
  endtask
endmodule // host_model

`default_nettype wire

// >>> hw/ddr_bus_pkg.sv
// Purpose: Shared constants and types for the DDR bus device slave
// Assumes: Six command/address bytes, most significant byte first
// Notes: Word addresses are 16-bit words; byte A is word bits 15:8
`default_nettype none

package ddr_bus_pkg;

  // ==========================================================
  // Command/address layout
  localparam int CA_W = 48;
  localparam int CA_RD_BIT = 47;
  localparam int CA_REG_BIT = 46;
  localparam int CA_LIN_BIT = 45;
  localparam int CA_COL_LO_W = 3;
  localparam int CA_ROW_LSB = 16;
  localparam logic [2:0] CA_LAST = 3'h5;
  localparam logic [2:0] ROW_LAST = 3'h3;

  // ==========================================================
  // Burst and mask values
  localparam int WRAP_MIN_WORDS = 8;
  localparam logic [1:0] BE_ALL = 2'h3;
  localparam logic STROBE_REST = 1'h0;

  // ==========================================================
  // Types
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_CA = 5'h02,
    ST_LAT = 5'h04,
    ST_RD = 5'h08,
    ST_WR = 5'h10
  } state_t;

  typedef struct packed {
    logic rd;
    logic reg_space;
    logic linear;
  } cmd_t;

  typedef struct packed {
    logic open;
    logic rd;
    logic wr;
    logic reg_space;
    logic [31:0] addr;
    logic [15:0] wdata;
    logic [1:0] be;
  } mem_req_t;

endpackage

`default_nettype wire

// >>> hw/dram_bus_slave.sv
// Purpose: Device-side transaction logic of a DDR bus DRAM slave
// Assumes: Bus clock and select are sampled by clk, far slower than clk
// Notes: Array and registers share one word port; reg_space selects them
`default_nettype none

// Notes on behaviour
// - Register reads: upper byte on rise, lower on fall
// - Register space always big-endian
// - Zero-latency writes store whole words, strobe released
// - First word bits pick read, space, burst type
// - Array access opens after bits 47:16
// - Strobe during command phase doubles latency
// - Strobe toggling and data start together
// - One byte per strobe edge, edge-aligned
// - Data continues while clock toggles, select low
// - Wrapped bursts wrap; linear bursts run on
// - Linear burst past end restarts at zero
// - Stopped bus clock is tolerated
// - Command phase takes first three clocks
// - Masked write: strobe high keeps byte
module dram_bus_slave
#(
  parameter int ADDR_W = 23,
  parameter int LAT_W = 4
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic bus_clock_line,
  input wire logic chip_select_b,
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  output logic dq_oe_b,
  input wire logic strobe_mask_line_in,
  output logic strobe_mask_line_out,
  output logic strobe_mask_line_oe_b,
  input wire logic [LAT_W-1:0] latency_count,
  input wire logic refresh_pending,
  input wire logic [1:0] wrap_len_sel,
  input wire logic [15:0] mem_rdata,
  output ddr_bus_pkg::mem_req_t mem_req
);
  import ddr_bus_pkg::*;

  // ==========================================================
  // Pin sampling
  logic ck_lvl;
  logic cs_lvl;
  logic [8:0] pins_lvl;
  logic ck_prev;
  logic cs_prev;

  pin_sync #(.W(1), .INIT(1'h0)) ck_sync (.clk(clk), .rst_b(rst_b),
    .d(bus_clock_line), .lvl(ck_lvl));
  pin_sync #(.W(1), .INIT(1'h1)) cs_sync (.clk(clk), .rst_b(rst_b),
    .d(chip_select_b), .lvl(cs_lvl));
  pin_sync #(.W(9), .INIT(9'h1ff)) pin_data_sync (.clk(clk), .rst_b(rst_b),
    .d({strobe_mask_line_in, dq_in}), .lvl(pins_lvl));

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ck_prev <= 1'h0;
      cs_prev <= 1'h1;
    end
    else
    begin
      ck_prev <= ck_lvl;
      cs_prev <= cs_lvl;
    end
  end

  // ==========================================================
  // Decode
  state_t state;
  state_t next_state;
  logic [2:0] byte_cnt;
  logic [CA_W-1:0] ca;
  cmd_t cmd;
  logic extra;
  logic [LAT_W:0] lat_cnt;
  logic [7:0] byte_a;
  logic mask_a;

  logic ck_rise;
  logic ck_fall;
  logic ck_edge;
  logic cs_fall;
  logic in_ca;
  logic in_data;
  logic ca_done;
  logic row_ready;
  logic lat_done;
  logic data_rise;
  logic data_fall;
  logic zero_lat;
  logic lat_rd;
  logic [7:0] dq_lvl;
  logic strobe_lvl;
  logic [CA_W-1:0] ca_next;
  cmd_t next_cmd;
  logic [LAT_W:0] lat_total;
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-1:0] addr_inc;
  logic [ADDR_W-1:0] wmask;
  logic [ADDR_W-1:0] next_addr;
  logic [ADDR_W-1:0] ca_addr;
  logic [ADDR_W-1:0] row_addr;

  assign dq_lvl = pins_lvl[7:0];
  assign strobe_lvl = pins_lvl[8];
  assign ck_rise = ck_lvl & ~ck_prev;
  assign ck_fall = ~ck_lvl & ck_prev;
  assign ck_edge = ck_rise | ck_fall;
  assign cs_fall = ~cs_lvl & cs_prev & ~ck_lvl;
  assign in_ca = state == ST_CA;
  assign in_data = (state == ST_RD) || (state == ST_WR);
  assign ca_next = {ca[CA_W-9:0], dq_lvl};
  assign ca_done = in_ca & ck_edge & (byte_cnt == CA_LAST);
  assign row_ready = in_ca & ck_edge & (byte_cnt == ROW_LAST);
  assign next_cmd.rd = ca_next[CA_RD_BIT];
  assign next_cmd.reg_space = ca_next[CA_REG_BIT];
  assign next_cmd.linear = ca_next[CA_LIN_BIT];
  assign zero_lat = ~next_cmd.rd & next_cmd.reg_space;
  assign lat_rd = ca_done ? next_cmd.rd : cmd.rd;
  assign lat_total = extra ? {latency_count, 1'h0} : {1'h0, latency_count};
  assign lat_done = (state == ST_LAT) & ck_rise & (lat_cnt == lat_total);
  assign data_rise = ck_rise & (in_data | lat_done);
  assign data_fall = ck_fall & in_data;
  assign addr = mem_req.addr[ADDR_W-1:0];
  assign addr_inc = addr + ADDR_W'(1);
  assign wmask = ADDR_W'((ADDR_W'(WRAP_MIN_WORDS) << wrap_len_sel) - ADDR_W'(1));
  assign next_addr = cmd.linear ? addr_inc : ((addr & ~wmask) | (addr_inc & wmask));
  assign ca_addr = {ca_next[ADDR_W+12:CA_ROW_LSB], ca_next[CA_COL_LO_W-1:0]};
  assign row_addr = {ca_next[ADDR_W-4:0], 3'h0};

  // ==========================================================
  // Sequencing
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (cs_fall)
          next_state = ST_CA;
      ST_CA:
        if (ca_done)
          next_state = zero_lat ? ST_WR : ST_LAT;
      ST_LAT:
        if (lat_done)
          next_state = cmd.rd ? ST_RD : ST_WR;
      default:
        next_state = state;
    endcase
    if (cs_lvl)
      next_state = ST_IDLE;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      byte_cnt <= 3'h0;
    else if (state == ST_IDLE)
      byte_cnt <= 3'h0;
    else if (in_ca & ck_edge)
      byte_cnt <= byte_cnt + 3'h1;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ca <= '0;
      cmd <= '0;
    end
    else if (in_ca & ck_edge)
    begin
      ca <= ca_next;
      if (ca_done)
        cmd <= next_cmd;
    end
  end

  // Refresh need is frozen at select so the strobe stays steady
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      extra <= 1'h0;
    else if (cs_fall)
      extra <= refresh_pending;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      lat_cnt <= '0;
    else if (ca_done)
      lat_cnt <= '0;
    else if ((state == ST_LAT) & ck_rise & ~lat_done)
      lat_cnt <= lat_cnt + (LAT_W+1)'(1);
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      byte_a <= 8'h00;
      mask_a <= 1'h0;
    end
    else if (data_rise & ~cmd.rd)
    begin
      byte_a <= dq_lvl;
      mask_a <= strobe_lvl;
    end
  end

  // ==========================================================
  // Array port
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      mem_req <= '0;
    else
    begin
      mem_req.open <= row_ready;
      mem_req.rd <= (ca_done & next_cmd.rd) | (data_fall & cmd.rd);
      mem_req.wr <= data_fall & ~cmd.rd;
      if (ca_done)
        mem_req.reg_space <= next_cmd.reg_space;
      if (row_ready)
        mem_req.addr <= 32'(row_addr);
      else if (ca_done)
        mem_req.addr <= 32'(ca_addr);
      // Writes step after the store, so each pulse carries its own word
      else if ((data_fall & cmd.rd) | mem_req.wr)
        mem_req.addr <= 32'(next_addr);
      if (data_fall & ~cmd.rd)
      begin
        mem_req.wdata <= {byte_a, dq_lvl};
        if (cmd.reg_space)
          mem_req.be <= BE_ALL;
        else
          mem_req.be <= ~{mask_a, strobe_lvl};
      end
    end
  end

  // ==========================================================
  // Pin drive
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dq_out <= 8'h00;
      dq_oe_b <= 1'h1;
    end
    else if (cs_lvl)
      dq_oe_b <= 1'h1;
    else if (data_rise & cmd.rd)
    begin
      dq_out <= mem_rdata[15:8];
      dq_oe_b <= 1'h0;
    end
    else if (data_fall & cmd.rd)
      dq_out <= mem_rdata[7:0];
  end

  // Write phases release the strobe so the host mask never contends
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      strobe_mask_line_out <= STROBE_REST;
      strobe_mask_line_oe_b <= 1'h1;
    end
    else if (next_state == ST_CA)
    begin
      strobe_mask_line_out <= cs_fall ? refresh_pending : extra;
      strobe_mask_line_oe_b <= 1'h0;
    end
    else if ((next_state == ST_LAT) && lat_rd)
    begin
      strobe_mask_line_out <= STROBE_REST;
      strobe_mask_line_oe_b <= 1'h0;
    end
    else if ((next_state == ST_RD) && (data_rise | data_fall))
      strobe_mask_line_out <= data_rise;
    else if (next_state != ST_RD)
    begin
      strobe_mask_line_out <= STROBE_REST;
      strobe_mask_line_oe_b <= 1'h1;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  select_end_a: assert property (cs_lvl |=> state == ST_IDLE && dq_oe_b)
    else $error("select high did not end transaction");
  ca_strobe_a: assert property (in_ca |-> !strobe_mask_line_oe_b
    && strobe_mask_line_out == extra)
    else $error("strobe wrong during command phase");
  upper_byte_a: assert property (data_rise && cmd.rd && !cs_lvl
    |=> dq_out == $past(mem_rdata[15:8]) && strobe_mask_line_out)
    else $error("upper byte not on strobe rise");
  lower_byte_a: assert property (data_fall && cmd.rd && !cs_lvl
    |=> dq_out == $past(mem_rdata[7:0]) && !strobe_mask_line_out)
    else $error("lower byte not on strobe fall");
  start_same_a: assert property (lat_done && cmd.rd && !cs_lvl
    |=> !dq_oe_b && !strobe_mask_line_oe_b && strobe_mask_line_out)
    else $error("data and strobe did not start together");
  full_word_a: assert property (mem_req.wr && mem_req.reg_space |-> mem_req.be == BE_ALL)
    else $error("zero latency write masked");
  mask_keep_a: assert property (data_fall && !cmd.rd && !cmd.reg_space
    |=> mem_req.be == ~{mask_a, $past(strobe_lvl)})
    else $error("byte enables do not follow mask");
  ca_three_a: assert property (ca_done && !cs_lvl |=> state != ST_CA)
    else $error("command phase overran six bytes");
  stall_hold_a: assert property (!ck_edge && !cs_lvl && state != ST_IDLE
    |=> $stable(state) && $stable(dq_out))
    else $error("state moved without bus clock edge");
  linear_step_a: assert property (((data_fall && cmd.rd) || mem_req.wr)
    && cmd.linear && !cs_lvl |=> addr == $past(addr) + ADDR_W'(1))
    else $error("linear burst address did not step");
  open_row_a: assert property (row_ready && !cs_lvl |=> mem_req.open ##1 !mem_req.open)
    else $error("row open pulse missing");

  reg_read_c: cover property (data_fall && cmd.rd && cmd.reg_space);
  masked_write_c: cover property (mem_req.wr && mem_req.be != BE_ALL);
  wrap_turn_c: cover property (data_fall && !cmd.linear && ((addr & wmask) == wmask));
  long_lat_c: cover property (lat_done && extra);

endmodule // dram_bus_slave

`default_nettype wire

// >>> hw/pin_sync.sv
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Input is asynchronous to clk
// Notes: Level moves only once stages two and three agree
`default_nettype none

module pin_sync
#(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] lvl
);

  // ==========================================================
  // Stages
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic agree;

  // First stage feeds only the second, to keep metastability contained
  assign agree = s2 == s3;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
    end
    else
    begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Reset to the pin's idle level, so no false edge follows release
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      lvl <= INIT;
    else if (agree)
      lvl <= s3;
  end

endmodule // pin_sync

`default_nettype wire
